// >>> verilog/lapre_pkg.sv
// Package: constants for the logic array register preload block
package lapre_pkg;
  // Array geometry
  localparam int N_INPUT_LINES = 40;
  localparam int N_PRODUCTS    = 64;
  localparam int N_REGS        = 8;
  localparam int TERMS_PER_OUT = 8;
  localparam int N_CELLS       = N_INPUT_LINES * N_PRODUCTS;
  // Map polarity: 0 connects, 1 disconnects
  localparam logic MAP_CONNECT    = 1'b0;
  localparam logic MAP_DISCONNECT = 1'b1;
  // Preload dwell time
  localparam int CLK_PERIOD_PS    = 8000;
  localparam int DWELL_TIME_NS    = 500;
  localparam int DWELL_CYCLES     = (DWELL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Device generation select
  localparam logic GEN_NEWER = 1'b1;
  localparam logic GEN_OLDER = 1'b0;
endpackage : lapre_pkg

// >>> verilog/lapre_core.sv
// Register array with preload, security lock and sum-of-products logic
`timescale 1ns/1ps
// Operation
// - Newer generation preload writes output registers on the rising clock edge once the dwell count completes.
// - Elevated level on control input for dwell time clears all registers low.
// - Elevated level on a disabled output pin for dwell time sets its register.
// - Older preload: high pin data loads register high, low data loads low.
// - Both super-high pins plus clock pulse load; removal restores normal inputs.
// - Programmed security cell refuses further programming and verify reads.
// - Preload works identically regardless of security cell state.
// - Map bit 0 means connection, 1 means no connection.
// - Cell index equals product line first cell plus input line number.
// - Product term true only when all connected lines high; both polarities false.
// - Output registers capture next state on rising edge of shared clock.
module lapre_core #(
  parameter logic GENERATION = lapre_pkg::GEN_NEWER,
  parameter int   DWELL      = lapre_pkg::DWELL_CYCLES
) (
  input  wire logic                                   clk,
  input  wire logic                                   rst_b,
  input  wire logic [19:0]                            array_in,
  input  wire logic                                   out_en_b,
  input  wire logic                                   elevated_control_level,
  input  wire logic [lapre_pkg::N_REGS-1:0]           pin_elevated,
  input  wire logic [lapre_pkg::N_REGS-1:0]           pin_data,
  input  wire logic                                   super_high_preload_level,
  input  wire logic                                   prog_req,
  input  wire logic [11:0]                            prog_addr,
  input  wire logic                                   prog_lock,
  input  wire logic                                   verify_req,
  output logic                                        verify_data,
  output logic                                        verify_refused,
  output logic                                        secured,
  output logic [lapre_pkg::N_REGS-1:0]                reg_out_b,
  output logic [lapre_pkg::N_REGS-1:0]                reg_oe
);
  localparam int NI = lapre_pkg::N_INPUT_LINES;
  localparam int NR = lapre_pkg::N_REGS;
  localparam int TP = lapre_pkg::TERMS_PER_OUT;

  // Pin synchronisers, two stages each
  logic [2:0]    s1_q, s2_q;
  logic [NR-1:0] ps1_q, ps2_q, ds1_q, ds2_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q  <= '0;
      s2_q  <= '0;
      ps1_q <= '0;
      ps2_q <= '0;
      ds1_q <= '0;
      ds2_q <= '0;
    end else begin
      s1_q  <= {out_en_b, elevated_control_level, super_high_preload_level};
      s2_q  <= s1_q;
      ps1_q <= pin_elevated;
      ps2_q <= ps1_q;
      ds1_q <= pin_data;
      ds2_q <= ds1_q;
    end
  end
  wire oe_b_s  = s2_q[2];
  wire ctl_s   = s2_q[1];
  wire shv_s   = s2_q[0];

  // Fuse map storage: cleared map reads all connect
  logic [lapre_pkg::N_CELLS-1:0] map_q;
  logic                          secured_q;
  wire  prog_ok   = prog_req & ~secured_q;
  wire  lock_ok   = prog_lock & ~secured_q;
  // Programming writes one map bit as a disconnect
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      map_q     <= '0;
      secured_q <= 1'b0;
    end else begin
      if (prog_ok && prog_addr < 12'(lapre_pkg::N_CELLS))
        map_q[prog_addr] <= lapre_pkg::MAP_DISCONNECT;
      if (lock_ok)
        secured_q <= 1'b1;
    end
  end

  // Verify path: refused once secured
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      verify_data    <= 1'b0;
      verify_refused <= 1'b0;
    end else begin
      verify_refused <= verify_req & secured_q;
      verify_data    <= (verify_req && !secured_q && prog_addr < 12'(lapre_pkg::N_CELLS)) ?
                        map_q[prog_addr] : 1'b0;
    end
  end
  assign secured = secured_q;

  // Array input lines: true and complement of each input, the first 8 inputs XORed with register feedback
  logic [NR-1:0] reg_q;
  wire  [NI-1:0] lines;
  wire  [NR*TP-1:0] pterm;
  wire  [NR-1:0] sop;
  genvar g, p;
  generate
    for (g = 0; g < NI/2; g++) begin : g_lines
      if (g < NR) begin : g_fb
        assign lines[2*g]   = array_in[g] ^ reg_q[g];
        assign lines[2*g+1] = ~(array_in[g] ^ reg_q[g]);
      end else begin : g_in
        assign lines[2*g]   = array_in[g];
        assign lines[2*g+1] = ~array_in[g];
      end
    end
    for (p = 0; p < NR*TP; p++) begin : g_pt
      // Cell index = product first cell plus input line
      wire [NI-1:0] conn = ~map_q[p*NI +: NI];
      assign pterm[p] = &(lines | ~conn);
    end
    for (g = 0; g < NR; g++) begin : g_or
      assign sop[g] = |pterm[g*TP +: TP];
    end
  endgenerate

  // Preload dwell counters; elevated level must persist for dwell time
  logic [15:0] clr_cnt_q;
  logic [15:0] set_cnt_q [NR];
  wire  clr_fire = (clr_cnt_q == 16'(DWELL - 1)) & ctl_s;
  wire  [NR-1:0] set_fire;
  wire  older_load = (GENERATION == lapre_pkg::GEN_OLDER) & shv_s & oe_b_s;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      clr_cnt_q <= '0;
    else
      clr_cnt_q <= (ctl_s && clr_cnt_q < 16'(DWELL)) ? clr_cnt_q + 16'h0001 : (ctl_s ? clr_cnt_q : 16'h0000);
  end
  generate
    for (g = 0; g < NR; g++) begin : g_set
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
          set_cnt_q[g] <= '0;
        else if (ps2_q[g] && oe_b_s && set_cnt_q[g] < 16'(DWELL))
          set_cnt_q[g] <= set_cnt_q[g] + 16'h0001;
        else if (!(ps2_q[g] && oe_b_s))
          set_cnt_q[g] <= 16'h0000;
      end
      assign set_fire[g] = ps2_q[g] & oe_b_s & (set_cnt_q[g] == 16'(DWELL - 1));
    end
  endgenerate

  // Output registers: preload beats normal capture; security never blocks it
  wire newer = (GENERATION == lapre_pkg::GEN_NEWER);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      reg_q <= '0;
    else if (newer && clr_fire)
      reg_q <= '0;
    else if (newer && |set_fire)
      reg_q <= reg_q | set_fire;
    else if (older_load)
      reg_q <= ds2_q;
    else
      reg_q <= sop;
  end

  // Active-low pins; driver on while enable low and no super-high phase
  assign reg_out_b = ~reg_q;
  assign reg_oe    = {NR{~oe_b_s & ~shv_s}};

  // Clear fires after dwell of elevated level
  property p_clear_after_dwell;
    @(posedge clk) disable iff (!rst_b)
    (newer && clr_fire) |=> (reg_q == '0);
  endproperty
  a_clear_after_dwell: assert property (p_clear_after_dwell) else $error("clear preload missed");

  property p_set_after_dwell;
    @(posedge clk) disable iff (!rst_b)
    (newer && !clr_fire && set_fire[0]) |=> reg_q[0];
  endproperty
  a_set_after_dwell: assert property (p_set_after_dwell) else $error("set preload missed");

  property p_verify_refused;
    @(posedge clk) disable iff (!rst_b)
    (verify_req && secured_q) |=> (verify_refused && !verify_data);
  endproperty
  a_verify_refused: assert property (p_verify_refused) else $error("verify not refused");

  property p_secured_sticks;
    @(posedge clk) disable iff (!rst_b)
    secured_q |=> secured_q;
  endproperty
  a_secured_sticks: assert property (p_secured_sticks) else $error("security cleared");

  property p_older_load;
    @(posedge clk) disable iff (!rst_b)
    older_load |=> (reg_q == $past(ds2_q));
  endproperty
  a_older_load: assert property (p_older_load) else $error("older preload wrong");

  property p_capture;
    @(posedge clk) disable iff (!rst_b)
    (!(newer && (clr_fire || |set_fire)) && !older_load) |=> (reg_q == $past(sop));
  endproperty
  a_capture: assert property (p_capture) else $error("capture wrong");

  property p_pins_inverse;
    @(posedge clk) disable iff (!rst_b)
    reg_out_b == ~reg_q;
  endproperty
  a_pins_inverse: assert property (p_pins_inverse) else $error("pin polarity wrong");

  property p_no_prog_when_secured;
    @(posedge clk) disable iff (!rst_b)
    secured_q |=> $stable(map_q);
  endproperty
  a_no_prog_when_secured: assert property (p_no_prog_when_secured) else $error("map changed");

  // Both polarities of one input on a term pin it false
  property p_pair_blocks_term;
    @(posedge clk) disable iff (!rst_b)
    (map_q[1:0] == 2'h0) |-> !pterm[0];
  endproperty
  a_pair_blocks_term: assert property (p_pair_blocks_term) else $error("paired term not false");
endmodule // lapre_core

// >>> verif/lapre_tester.sv
// Tester model driving the preload and programming pins
`timescale 1ns/1ps
module lapre_tester #(
  parameter int DWELL = 4
) (
  input  wire logic        clk,
  output logic             out_en_b,
  output logic             elevated_control_level,
  output logic [7:0]       pin_elevated,
  output logic [7:0]       pin_data,
  output logic             super_high_preload_level,
  output logic             prog_req,
  output logic [11:0]      prog_addr,
  output logic             prog_lock,
  output logic             verify_req
);
  initial begin
    {out_en_b, elevated_control_level, pin_elevated, pin_data} = '0;
    {super_high_preload_level, prog_req, prog_addr, prog_lock, verify_req} = '0;
  end
  // Pins change on the falling edge only
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Counted dwell with margin for the input synchronisers
  task automatic dwell();
    cyc(DWELL + 4);
  endtask
  task automatic clear_all();
    elevated_control_level = 1'b1;
    dwell();
    elevated_control_level = 1'b0;
    cyc(4);
  endtask
  // Outputs off first, then elevated pins; left held for the check
  task automatic set_regs(input logic [7:0] mask);
    out_en_b = 1'b1;
    dwell();
    pin_elevated = mask;
    dwell();
  endtask
  task automatic set_done();
    pin_elevated = 8'h00;
    out_en_b = 1'b0;
    cyc(4);
  endtask
  // Older load: data on pins, super-high held over clock pulses
  task automatic old_load(input logic [7:0] d);
    out_en_b = 1'b1;
    pin_data = d;
    cyc(2);
    super_high_preload_level = 1'b1;
    cyc(4);
  endtask
  // Super-high off first, outputs back on only after it has settled
  task automatic old_done();
    super_high_preload_level = 1'b0;
    pin_data = ~pin_data;
    cyc(2);
    out_en_b = 1'b0;
    cyc(4);
  endtask
  // Lock request alone, so no cell is burnt with it
  task automatic prog(input logic [11:0] a, input logic lock);
    prog_addr = a;
    prog_lock = lock;
    prog_req = !lock;
    cyc(1);
    {prog_req, prog_lock} = 2'h0;
    cyc(4);
  endtask
  // One product row: burn the ones, leave the zeros as connections
  task automatic prog_map(input logic [11:0] base, input logic [39:0] row);
    for (int i = 0; i < 40; i++) begin
      prog_addr = base + 12'(i);
      prog_req = row[i];
      cyc(1);
    end
    prog_req = 1'b0;
    cyc(1);
  endtask
  // Read-back stands one cycle only; caller samples it on return
  task automatic verify(input logic [11:0] a);
    prog_addr = a;
    verify_req = 1'b1;
    cyc(1);
    verify_req = 1'b0;
  endtask
endmodule // lapre_tester

// >>> verif/tb_top.sv
// Testbench for the register preload block, both generations
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [19:0] array_in = 20'h00000;
  logic        oe_b, elev, shp, preq, lock, vreq, vdata, vref, sec, old_vdata, old_vref, old_sec;
  logic [7:0]  pel, pdat, rout_b, roe, old_b, old_oe;
  logic [11:0] paddr;
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  always #4 clk = ~clk;
  lapre_tester #(.DWELL(4)) lapre_tester_i (.clk(clk), .out_en_b(oe_b), .elevated_control_level(elev),
    .pin_elevated(pel), .pin_data(pdat), .super_high_preload_level(shp), .prog_req(preq),
    .prog_addr(paddr), .prog_lock(lock), .verify_req(vreq));
  lapre_core #(.GENERATION(lapre_pkg::GEN_NEWER), .DWELL(4)) lapre_core_i (.clk(clk), .rst_b(rst_b),
    .array_in(array_in), .out_en_b(oe_b), .elevated_control_level(elev), .pin_elevated(pel),
    .pin_data(pdat), .super_high_preload_level(shp), .prog_req(preq), .prog_addr(paddr),
    .prog_lock(lock), .verify_req(vreq), .verify_data(vdata), .verify_refused(vref),
    .secured(sec), .reg_out_b(rout_b), .reg_oe(roe));
  lapre_core #(.GENERATION(lapre_pkg::GEN_OLDER), .DWELL(4)) old_i (.clk(clk), .rst_b(rst_b),
    .array_in(array_in), .out_en_b(oe_b), .elevated_control_level(elev), .pin_elevated(pel),
    .pin_data(pdat), .super_high_preload_level(shp), .prog_req(preq), .prog_addr(paddr),
    .prog_lock(lock), .verify_req(vreq), .verify_data(old_vdata), .verify_refused(old_vref),
    .secured(old_sec), .reg_out_b(old_b), .reg_oe(old_oe));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end
  task automatic t_set(input logic [7:0] m);
    lapre_tester_i.set_regs(m);
    check("oe off", 8'h00, roe);
    check("set pins", ~m, rout_b);
    lapre_tester_i.set_done();
    check("held pins", ~m, rout_b);
    check("oe on", 8'hFF, roe);
    // One clock with inverted feedback flips every held register
    array_in = 20'h000FF;
    lapre_tester_i.cyc(1);
    array_in = 20'h00000;
    lapre_tester_i.cyc(1);
    check("toggled pins", m, rout_b);
    lapre_tester_i.clear_all();
    check("clear pins", 8'hFF, rout_b);
    $display("set and clear done");
  endtask
  task automatic t_old();
    lapre_tester_i.old_load(8'h3C);
    check("old load", 8'hC3, old_b);
    check("old oe off", 8'h00, old_oe);
    lapre_tester_i.old_done();
    check("old held", 8'hC3, old_b);
    check("old oe on", 8'hFF, old_oe);
    $display("older load done");
  endtask
  task automatic t_map();
    // First term of each group keeps only its register's true feedback line, so registers hold
    for (int g = 0; g < 8; g++) lapre_tester_i.prog_map(12'(g * 320), ~(40'h1 << (2 * g)));
    lapre_tester_i.prog(12'h02D, 1'b0);
    lapre_tester_i.verify(12'h02D);
    check("cell 45", 8'h03, {6'h00, old_vdata, vdata});
    check("not refused", 8'h00, {6'h00, old_vref, vref});
    lapre_tester_i.cyc(4);
    lapre_tester_i.verify(12'h001);
    check("cell 1", 8'h03, {6'h00, old_vdata, vdata});
    lapre_tester_i.cyc(4);
    lapre_tester_i.verify(12'h02E);
    check("cell 46", 8'h00, {6'h00, old_vdata, vdata});
    lapre_tester_i.cyc(4);
    $display("map done");
  endtask
  task automatic t_secure();
    lapre_tester_i.prog(12'h000, 1'b1);
    check("secured", 8'h03, {6'h00, old_sec, sec});
    lapre_tester_i.prog(12'h050, 1'b0);
    lapre_tester_i.verify(12'h02D);
    check("refused", 8'h03, {6'h00, old_vref, vref});
    check("refused data", 8'h00, {6'h00, old_vdata, vdata});
    lapre_tester_i.cyc(4);
    t_set(8'h0F);
    t_old();
    $display("security done");
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    check("reset pins", 8'hFF, rout_b);
    check("reset oe", 8'hFF, roe);
    t_map();
    t_set(8'hA5);
    t_old();
    t_secure();
    conclude();
  end
endmodule // tb_top
